// File: rtl/dbg_trig_pkg.sv
// Constants and types for the debug trigger and breakpoint block
package dbg_trig_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_COMP_A = 5'h00;
  localparam logic [4:0] OFS_COMP_B = 5'h04;
  localparam logic [4:0] OFS_FIFO_HIGH = 5'h08;
  localparam logic [4:0] OFS_FIFO_LOW = 5'h0C;
  localparam logic [4:0] OFS_CONTROL = 5'h10;
  localparam logic [4:0] OFS_TRIGGER = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;
  localparam logic [4:0] OFS_BDC_CTRL = 5'h1C;
  // Control register bits
  localparam int CTL_ENABLE = 0;
  localparam int CTL_RUN_START = 1;
  localparam int CTL_BREAK_KIND = 2;
  localparam int CTL_BREAK_EN = 3;
  localparam int CTL_QA_EN = 4;
  localparam int CTL_QA_VAL = 5;
  localparam int CTL_QB_EN = 6;
  localparam int CTL_QB_VAL = 7;
  // Trigger register fields
  localparam int TRIG_MODE_LSB = 0;
  localparam int TRIG_BEGIN = 6;
  localparam int TRIG_FETCH_SEL = 7;
  // Status register fields
  localparam int STS_MATCH_A = 0;
  localparam int STS_MATCH_B = 1;
  localparam int STS_RUN = 2;
  localparam int STS_COUNT_LSB = 4;
  // Trigger modes
  localparam logic [3:0] MODE_A_ONLY = 4'h0;
  localparam logic [3:0] MODE_A_OR_B = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] MODE_A_AND_B_DATA = 4'h3;
  localparam logic [3:0] MODE_A_AND_NOT_B = 4'h4;
  localparam logic [3:0] MODE_EVENT_B = 4'h5;
  localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h6;
  localparam logic [3:0] MODE_INSIDE = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE = 4'h8;
  // Capture FIFO and opcode queue sizes
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FIFO_FULL_COUNT = 4'h8;
  localparam int QUEUE_DEPTH = 4;
  localparam logic [2:0] QUEUE_FULL_COUNT = 3'h4;
  // Opcode queue entry bits
  localparam int QE_A = 0;
  localparam int QE_B = 1;
  localparam int QE_BRK = 2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT_TRIG = 4'b0010,
    ST_STORING = 4'b0100,
    ST_END_TRACE = 4'b1000
  } run_state_t;
endpackage : dbg_trig_pkg

// File: rtl/debug_trigger_breakpoint.sv
// Debug comparators, trigger modes, capture FIFO and CPU breakpoint requests
// Operation
// RULE1: Tagged opcode marked at fetch; acts only if executed; flushed opcodes do nothing.
// RULE2: Force break waits for current instruction to finish, then enters background.
// RULE3: Tag marker rides the queue with opcode; on execution background is entered.
// RULE4: With fetch trigger select, matches count only once the opcode executes.
// RULE5: Each comparator has its own opcode tracking column in the queue.
// RULE6: A 4-bit mode field selects one of nine trigger modes.
// RULE7: Begin bit picks begin-trace or circular end-trace capture.
// RULE8: Writing run start sets run flag and clears match flags and count.
// RULE9: Begin-trace ends when FIFO full; end-trace ends at trigger.
// RULE10: Writing 0 to run start or enable stops the run at once.
// RULE11: FIFO holds change-of-flow addresses, or data bytes in event-only modes.
// RULE12: Event-only modes ignore the begin bit and always act as begin-trace.
// RULE13: Each comparator may be qualified by read/write matching its value bit.
// RULE14: With break enable, the trigger requests a CPU break of selected kind.
// RULE15: A-only triggers on A match; A-or-B on either match.
// RULE16: A-then-B triggers on B match after any earlier A match.
// RULE17: A-and-B-data needs A address and B low byte data in one cycle.
// RULE18: A-and-not-B-data needs A address and differing data in one cycle.
// RULE19: Tag break in full data modes follows the A address match only.
// RULE20: Event-only modes store bus data on each B match until FIFO full.
// RULE21: Inside range triggers on A<=addr<=B; outside on addr<A or addr>B.
// RULE22: Without background permit a break executes a software interrupt instead.
// RULE23: Comparators are suspended during every background controller access.
// RULE24: Full modes compare write data when A qualifies on writes, else read data.
// RULE25: Each read of the FIFO low byte shifts the next entry into view.
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module debug_trigger_breakpoint
  import dbg_trig_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [15:0] cpu_addr_in,
  input wire logic [7:0] cpu_rdata_in,
  input wire logic [7:0] cpu_wdata_in,
  input wire logic cpu_rw_in,
  input wire logic cpu_valid_in,
  input wire logic cpu_fetch_in,
  input wire logic cpu_exec_in,
  input wire logic cpu_flush_in,
  input wire logic cof_valid_in,
  input wire logic [15:0] cof_addr_in,
  input wire logic bdc_access_in,
  output logic tag_mark_out,
  output logic force_pending_out,
  output logic halt_enter_out,
  output logic trap_enter_out
);

  function automatic logic rw_ok(input logic en, input logic val, input logic rw);
    rw_ok = !en || (rw == val);
  endfunction : rw_ok

  logic [15:0] comp_a;
  logic [15:0] comp_b;
  logic [7:0] control;
  logic [7:0] trigger;
  logic permit;
  logic match_a_flag;
  logic match_b_flag;
  logic [3:0] fifo_word_count;
  logic [15:0] fifo [0:FIFO_DEPTH-1];
  logic [2:0] queue [0:QUEUE_DEPTH-1];
  logic [2:0] q_len;
  run_state_t state;
  run_state_t next_state;

  // Bus slave: one wait cycle, then the access completes
  wire req = avs_read_in || avs_write_in;
  wire accept = req && !avs_waitrequest_out;
  wire wr_ctl = accept && avs_write_in && (avs_address_in == OFS_CONTROL);
  wire rd_low = accept && avs_read_in && (avs_address_in == OFS_FIFO_LOW);
  wire run_active = (state != ST_IDLE);

  wire [3:0] mode = trigger[TRIG_MODE_LSB +: 4];
  wire is_event = (mode == MODE_EVENT_B) || (mode == MODE_A_THEN_EVENT_B);
  wire is_full = (mode == MODE_A_AND_B_DATA) || (mode == MODE_A_AND_NOT_B);
  wire begin_mode = trigger[TRIG_BEGIN] || is_event; // RULE12
  wire fetch_sel = trigger[TRIG_FETCH_SEL];
  wire enabled = control[CTL_ENABLE];

  // Comparators
  wire bus_ok = cpu_valid_in && !bdc_access_in; // RULE23
  wire rw_qa = rw_ok(control[CTL_QA_EN], control[CTL_QA_VAL], cpu_rw_in); // RULE13
  wire rw_qb = rw_ok(control[CTL_QB_EN], control[CTL_QB_VAL], cpu_rw_in); // RULE13
  wire addr_a_hit = bus_ok && (cpu_addr_in == comp_a) && rw_qa;
  wire addr_b_hit = bus_ok && (cpu_addr_in == comp_b) && rw_qb;
  wire use_wdata = control[CTL_QA_EN] && !control[CTL_QA_VAL];
  wire [7:0] data_bus = use_wdata ? cpu_wdata_in : cpu_rdata_in; // RULE24
  wire data_hit = (data_bus == comp_b[7:0]);
  wire in_range = bus_ok && (cpu_addr_in >= comp_a) && (cpu_addr_in <= comp_b);
  wire out_range = bus_ok && ((cpu_addr_in < comp_a) || (cpu_addr_in > comp_b));

  // Opcode tracking: head entry retires when the CPU executes it
  wire [2:0] q_head = queue[0];
  wire head_valid = (q_len != 3'h0);
  wire exec_head = cpu_exec_in && head_valid && !cpu_flush_in;
  wire a_evt = fetch_sel ? (exec_head && q_head[QE_A]) : addr_a_hit; // RULE4
  wire b_evt = fetch_sel ? (exec_head && q_head[QE_B]) : addr_b_hit; // RULE4

  logic trig;
  always_comb begin
    trig = 1'b0;
    case (mode) // RULE6
      MODE_A_ONLY: trig = a_evt; // RULE15
      MODE_A_OR_B: trig = a_evt || b_evt; // RULE15
      MODE_A_THEN_B: trig = b_evt && match_a_flag; // RULE16
      MODE_A_AND_B_DATA: trig = a_evt && data_hit; // RULE17
      MODE_A_AND_NOT_B: trig = a_evt && !data_hit; // RULE18
      MODE_EVENT_B: trig = b_evt; // RULE20
      MODE_A_THEN_EVENT_B: trig = b_evt && match_a_flag; // RULE20
      MODE_INSIDE: trig = in_range; // RULE21
      MODE_OUTSIDE: trig = out_range; // RULE21
      default: trig = 1'b0;
    endcase
  end

  // Break requests
  wire brk_on = enabled && control[CTL_BREAK_EN]; // RULE14
  wire tag_kind = control[CTL_BREAK_KIND];
  wire tag_cond = is_full ? addr_a_hit : trig; // RULE19
  wire tag_now = brk_on && tag_kind && cpu_fetch_in && tag_cond; // RULE1
  wire force_now = brk_on && !tag_kind && trig; // RULE14
  // Break taken at the instruction boundary, from either the force or a tagged head
  wire brk_take = (cpu_exec_in && force_pending_out) || (exec_head && q_head[QE_BRK]); // RULE2 RULE3

  // Run control
  wire arm_write = wr_ctl && avs_writedata_in[CTL_RUN_START] && avs_writedata_in[CTL_ENABLE];
  wire stop_write = wr_ctl && !arm_write; // RULE10
  wire fifo_full = (fifo_word_count == FIFO_FULL_COUNT);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (arm_write) begin
          next_state = begin_mode ? (is_event ? ST_STORING : ST_WAIT_TRIG) : ST_END_TRACE; // RULE7
        end
      end
      ST_WAIT_TRIG: begin
        if (stop_write) begin
          next_state = ST_IDLE;
        end else if (trig) begin
          next_state = ST_STORING; // RULE7
        end
      end
      ST_STORING: begin
        if (stop_write || fifo_full) begin
          next_state = ST_IDLE; // RULE9
        end
      end
      ST_END_TRACE: begin
        if (stop_write || trig) begin
          next_state = ST_IDLE; // RULE9
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Capture: addresses normally, data byte in event-only modes
  wire push_cof = !is_event && cof_valid_in &&
    ((state == ST_STORING) || (state == ST_END_TRACE)); // RULE11
  wire push_evt = is_event && (state == ST_STORING) && trig; // RULE20
  wire push = (push_cof || push_evt) && !rd_low && !arm_write;
  wire [15:0] push_word = is_event ? {8'h00, data_bus} : cof_addr_in; // RULE11
  wire pop = rd_low && (fifo_word_count != 4'h0);

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fifo_word_count <= 4'h0;
    end else if (arm_write) begin
      fifo_word_count <= 4'h0; // RULE8
    end else if (pop) begin
      fifo_word_count <= fifo_word_count - 4'h1; // RULE25
    end else if (push && !fifo_full) begin
      fifo_word_count <= fifo_word_count + 4'h1;
    end
  end

  // Shift-register FIFO: entry 0 is the one visible at the data port
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      if (pop) begin
        fifo[i] <= (i == FIFO_DEPTH - 1) ? 16'h0000 : fifo[i+1]; // RULE25
      end else if (push && fifo_full && (state == ST_END_TRACE)) begin
        // Circular store drops the oldest entry
        fifo[i] <= (i == FIFO_DEPTH - 1) ? push_word : fifo[i+1]; // RULE7
      end else if (push && !fifo_full && (fifo_word_count == 4'(i))) begin
        fifo[i] <= push_word;
      end
    end
  end

  // Match flags: a new match wins over the clear from a run start only while a run is already active
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      match_a_flag <= 1'b0;
      match_b_flag <= 1'b0;
    end else begin
      match_a_flag <= (match_a_flag && !arm_write) || (run_active && a_evt); // RULE8
      match_b_flag <= (match_b_flag && !arm_write) || (run_active && b_evt); // RULE8
    end
  end

  // Opcode queue with one column per comparator plus the break tag
  wire q_push = cpu_fetch_in && !cpu_flush_in && (q_len != QUEUE_FULL_COUNT);
  wire [2:0] q_entry = {tag_now, addr_b_hit, addr_a_hit}; // RULE5
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q_len <= 3'h0;
    end else if (cpu_flush_in) begin
      q_len <= 3'h0; // RULE1
    end else begin
      q_len <= q_len + 3'(q_push) - 3'(exec_head);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < QUEUE_DEPTH; i++) begin
      if (exec_head) begin
        if (q_push && (3'(i) == q_len - 3'h1)) begin
          queue[i] <= q_entry;
        end else if (i < QUEUE_DEPTH - 1) begin
          queue[i] <= queue[i+1];
        end
      end else if (q_push && (3'(i) == q_len)) begin
        queue[i] <= q_entry; // RULE3
      end
    end
  end

  // CPU break outputs
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tag_mark_out <= 1'b0;
      force_pending_out <= 1'b0;
      halt_enter_out <= 1'b0;
      trap_enter_out <= 1'b0;
    end else begin
      tag_mark_out <= tag_now && q_push; // RULE1
      force_pending_out <= force_now || (force_pending_out && !cpu_exec_in); // RULE2
      halt_enter_out <= brk_take && permit; // RULE3
      trap_enter_out <= brk_take && !permit; // RULE22
    end
  end

  // Register writes
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      comp_a <= 16'h0000;
      comp_b <= 16'h0000;
      control <= 8'h00;
      trigger <= 8'h00;
      permit <= 1'b0;
    end else if (accept && avs_write_in) begin
      if (avs_address_in == OFS_COMP_A) begin
        comp_a <= avs_writedata_in[15:0];
      end else if (avs_address_in == OFS_COMP_B) begin
        comp_b <= avs_writedata_in[15:0];
      end else if (avs_address_in == OFS_CONTROL) begin
        control <= avs_writedata_in[7:0];
      end else if (avs_address_in == OFS_TRIGGER) begin
        trigger <= avs_writedata_in[7:0];
      end else if (avs_address_in == OFS_BDC_CTRL) begin
        permit <= avs_writedata_in[0];
      end
    end
  end

  // Read mux; the run start bit reads back the live run state
  wire [7:0] status = {fifo_word_count, 1'b0, run_active, match_b_flag, match_a_flag};
  wire [7:0] ctl_rd = {control[7:2], run_active, control[CTL_ENABLE]};
  wire [31:0] rd_mux =
    (avs_address_in == OFS_COMP_A) ? {16'h0000, comp_a} :
    (avs_address_in == OFS_COMP_B) ? {16'h0000, comp_b} :
    (avs_address_in == OFS_FIFO_HIGH) ? {24'h00_0000, fifo[0][15:8]} :
    (avs_address_in == OFS_FIFO_LOW) ? {24'h00_0000, fifo[0][7:0]} :
    (avs_address_in == OFS_CONTROL) ? {24'h00_0000, ctl_rd} :
    (avs_address_in == OFS_TRIGGER) ? {24'h00_0000, trigger} :
    (avs_address_in == OFS_STATUS) ? {24'h00_0000, status} :
    (avs_address_in == OFS_BDC_CTRL) ? {31'h0000_0000, permit} : 32'h0000_0000;

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      avs_waitrequest_out <= !(req && avs_waitrequest_out);
      if (req && avs_waitrequest_out) begin
        avs_readdata_out <= rd_mux;
      end
    end
  end

  // Checks
  property p_arm_clears;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    arm_write && !run_active |=> run_active && fifo_word_count == 4'h0 && !(match_a_flag && !$past(a_evt));
  endproperty
  a_arm_clears: assert property (p_arm_clears) else $error("run start did not arm and clear"); // RULE8

  property p_stop;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    stop_write |=> !run_active;
  endproperty
  a_stop: assert property (p_stop) else $error("run not stopped by control write"); // RULE10

  property p_full_ends;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    state == ST_STORING && fifo_full |=> state == ST_IDLE;
  endproperty
  a_full_ends: assert property (p_full_ends) else $error("begin trace ran past full FIFO"); // RULE9

  property p_end_trig;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    state == ST_END_TRACE && trig |=> state == ST_IDLE;
  endproperty
  a_end_trig: assert property (p_end_trig) else $error("end trace not ended by trigger"); // RULE9

  property p_force_waits;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    force_pending_out && !cpu_exec_in |=> force_pending_out && !halt_enter_out && !trap_enter_out;
  endproperty
  a_force_waits: assert property (p_force_waits) else $error("force break acted early"); // RULE2

  property p_trap;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    brk_take && !permit |=> trap_enter_out && !halt_enter_out;
  endproperty
  a_trap: assert property (p_trap) else $error("break without permit did not trap"); // RULE22

  property p_flush;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    cpu_flush_in |=> q_len == 3'h0 ##1
      (!halt_enter_out && !trap_enter_out || $past(force_pending_out));
  endproperty
  a_flush: assert property (p_flush) else $error("flushed opcodes still tracked"); // RULE1

  property p_bdc_quiet;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    bdc_access_in |-> !addr_a_hit && !addr_b_hit && !in_range && !out_range;
  endproperty
  a_bdc_quiet: assert property (p_bdc_quiet) else $error("comparator matched during BDC access"); // RULE23

  property p_read_shift;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    pop && !arm_write |=> fifo_word_count == $past(fifo_word_count) - 4'h1;
  endproperty
  a_read_shift: assert property (p_read_shift) else $error("low byte read did not shift FIFO"); // RULE25

  property p_inside;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
    mode == MODE_INSIDE && bus_ok && cpu_addr_in >= comp_a && cpu_addr_in <= comp_b |-> trig;
  endproperty
  a_inside: assert property (p_inside) else $error("inside range missed"); // RULE21

  c_begin_run: cover property (@(posedge ref_clk_in) state == ST_WAIT_TRIG ##[1:50] state == ST_STORING);
  c_end_run: cover property (@(posedge ref_clk_in) state == ST_END_TRACE ##1 state == ST_IDLE);
  c_tag_break: cover property (@(posedge ref_clk_in) tag_mark_out ##[1:20] halt_enter_out);
  c_force_trap: cover property (@(posedge ref_clk_in) force_pending_out ##[1:20] trap_enter_out);

endmodule : debug_trigger_breakpoint
`default_nettype wire

// File: testbench/cpu_core_model.sv
// Behavioural CPU core: bus cycles, queue events, counts of break responses
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model (
  input wire logic clk_in,
  input wire logic tag_mark_in,
  input wire logic halt_enter_in,
  input wire logic trap_enter_in,
  output logic [15:0] addr_out,
  output logic [7:0] rdata_out,
  output logic [7:0] wdata_out,
  output logic rw_out,
  output logic valid_out,
  output logic fetch_out,
  output logic exec_out,
  output logic flush_out,
  output logic cof_valid_out,
  output logic [15:0] cof_addr_out,
  output logic bdc_out
);
  int n_tag = 0;
  int n_halt = 0;
  int n_trap = 0;
  initial begin
    {addr_out, rdata_out, wdata_out, cof_addr_out} = '0;
    {rw_out, valid_out, fetch_out, exec_out, flush_out, cof_valid_out, bdc_out} = '0;
  end
  // Responses are only counted here; the bench judges them
  always @(posedge clk_in) begin
    n_tag += int'(tag_mark_in === 1'b1);
    n_halt += int'(halt_enter_in === 1'b1);
    n_trap += int'(trap_enter_in === 1'b1);
  end
  // The unused data bus carries the inverse, so a wrong bus choice shows
  task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic rw,
      input logic bdc, input logic f);
    addr_out <= a;
    rdata_out <= rw ? d : ~d;
    wdata_out <= rw ? ~d : d;
    rw_out <= rw;
    bdc_out <= bdc;
    fetch_out <= f;
    valid_out <= 1'b1;
    @(posedge clk_in);
    // Released buses show junk, never the last value
    addr_out <= ~a;
    rdata_out <= d ^ 8'hA5;
    wdata_out <= d ^ 8'h5A;
    valid_out <= 1'b0;
    fetch_out <= 1'b0;
    bdc_out <= 1'b0;
    @(posedge clk_in);
  endtask : cycle
  // Kind 0 executes, 1 flushes the queue, 2 reports a change of flow
  task automatic pulse(input int kind, input logic [15:0] a);
    exec_out <= (kind == 0);
    flush_out <= (kind == 1);
    cof_valid_out <= (kind == 2);
    cof_addr_out <= a;
    @(posedge clk_in);
    {exec_out, flush_out, cof_valid_out} <= 3'h0;
    cof_addr_out <= ~a;
    @(posedge clk_in);
  endtask : pulse
endmodule : cpu_core_model
`default_nettype wire

// File: testbench/tb_debug_trigger_breakpoint.sv
// Self-checking bench: registers, trigger modes, capture FIFO, CPU breaks
`timescale 1ns/100ps
`default_nettype none
module tb_debug_trigger_breakpoint;
  import dbg_trig_pkg::*;
  localparam logic [15:0] ADR_A = 16'h1000;
  localparam logic [15:0] ADR_B = 16'h2055;
  logic clk, rst, rd_en, wr_en, stall, valid, fetch, exec, flush, rw, cofv, bdc;
  logic tag, pend, halt, trap;
  logic [4:0] adr;
  logic [31:0] wdat, rdat;
  logic [15:0] caddr, cofa;
  logic [7:0] crd, cwd;
  int n_errors = 0;
  int total_checks = 0;
  debug_trigger_breakpoint i_debug_trigger_breakpoint (.ref_clk_in(clk), .sys_rst_in(rst),
    .avs_address_in(adr), .avs_read_in(rd_en), .avs_write_in(wr_en),
    .avs_writedata_in(wdat), .avs_readdata_out(rdat), .avs_waitrequest_out(stall),
    .cpu_addr_in(caddr), .cpu_rdata_in(crd), .cpu_wdata_in(cwd), .cpu_rw_in(rw),
    .cpu_valid_in(valid), .cpu_fetch_in(fetch), .cpu_exec_in(exec), .cpu_flush_in(flush),
    .cof_valid_in(cofv), .cof_addr_in(cofa), .bdc_access_in(bdc), .tag_mark_out(tag),
    .force_pending_out(pend), .halt_enter_out(halt), .trap_enter_out(trap));
  cpu_core_model i_cpu_core_model (.clk_in(clk), .tag_mark_in(tag), .halt_enter_in(halt),
    .trap_enter_in(trap), .addr_out(caddr), .rdata_out(crd), .wdata_out(cwd), .rw_out(rw),
    .valid_out(valid), .fetch_out(fetch), .exec_out(exec), .flush_out(flush),
    .cof_valid_out(cofv), .cof_addr_out(cofa), .bdc_out(bdc));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // Request held until waitrequest is sampled low; a dead bus ends the run
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int k;
    k = 0;
    adr <= a;
    wdat <= d;
    wr_en <= w;
    rd_en <= ~w;
    do begin
      @(posedge clk);
      k++;
    end while (stall !== 1'b0 && k < 20);
    q = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (stall !== 1'b0) begin
      n_errors++;
      end_of_test();
    end
    @(posedge clk);
  endtask : acc
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
      input string s);
    logic [31:0] q;
    acc(1'b0, a, 32'h0000_0000, q);
    chk(s, e, q & m);
  endtask : rd
  task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic [2:0] f);
    i_cpu_core_model.cycle(a, d, f[2], f[1], f[0]);
  endtask : cyc
  task automatic ev(input int kind, input logic [15:0] a);
    i_cpu_core_model.pulse(kind, a);
  endtask : ev
  // Flags are {prior A cycle, read, background access, break expected}
  task automatic rc(input logic [7:0] ctl, input logic [3:0] mode, input logic [15:0] a,
      input logic [7:0] d, input logic [3:0] fl);
    int nb;
    wr(OFS_TRIGGER, {24'h00_0000, 4'h4, mode});
    wr(OFS_CONTROL, {24'h00_0000, ctl});
    if (fl[3]) cyc(ADR_A, 8'h00, 3'h4);
    nb = i_cpu_core_model.n_halt + i_cpu_core_model.n_trap;
    cyc(a, d, {fl[2], fl[1], 1'b0});
    repeat (2) @(posedge clk);
    chk("break pending", 32'(fl[0]), 32'(pend));
    ev(0, 16'h0000);
    @(posedge clk);
    chk("break taken", 32'(fl[0]),
        32'(i_cpu_core_model.n_halt + i_cpu_core_model.n_trap - nb));
    wr(OFS_CONTROL, 32'h0000_0001);
  endtask : rc
  initial begin
    logic [7:0] e;
    int nt;
    int nb;
    {rst, rd_en, wr_en, adr, wdat} = {1'b1, 39'h00_0000_0000};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, "status at reset");
    rd(OFS_CONTROL, 32'hFFFF_FFFF, 32'h0000_0000, "control at reset");
    rd(5'h02, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    wr(OFS_COMP_A, {16'h0000, ADR_A});
    wr(OFS_COMP_B, {16'h0000, ADR_B});
    rd(OFS_COMP_A, 32'hFFFF_FFFF, {16'h0000, ADR_A}, "comparator A");
    rc(8'h0B, MODE_A_ONLY, ADR_A, 8'h00, 4'h5);
    chk("soft interrupt", 32'h0000_0001, 32'(i_cpu_core_model.n_trap));
    wr(OFS_BDC_CTRL, 32'h0000_0001);
    rc(8'h0B, MODE_A_ONLY, ADR_B, 8'h00, 4'h4);
    rc(8'h0B, MODE_A_OR_B, ADR_B, 8'h00, 4'h5);
    rc(8'h0B, MODE_A_THEN_B, ADR_B, 8'h00, 4'h4);
    rc(8'h0B, MODE_A_THEN_B, ADR_B, 8'h00, 4'hD);
    rc(8'h0B, MODE_A_AND_B_DATA, ADR_A, 8'h55, 4'h5);
    rc(8'h0B, MODE_A_AND_B_DATA, ADR_A, 8'h54, 4'h4);
    rc(8'h0B, MODE_A_AND_NOT_B, ADR_A, 8'h54, 4'h5);
    rc(8'h0B, MODE_A_AND_NOT_B, ADR_A, 8'h55, 4'h4);
    rc(8'h0B, MODE_A_AND_B_DATA, ADR_A, 8'h55, 4'h0);
    rc(8'h1B, MODE_A_AND_B_DATA, ADR_A, 8'h55, 4'h1);
    rc(8'h3B, MODE_A_ONLY, ADR_A, 8'h00, 4'h0);
    rc(8'h3B, MODE_A_ONLY, ADR_A, 8'h00, 4'h5);
    rc(8'hCB, MODE_A_OR_B, ADR_B, 8'h00, 4'h0);
    rc(8'hCB, MODE_A_OR_B, ADR_B, 8'h00, 4'h5);
    rc(8'h0B, MODE_INSIDE, ADR_A, 8'h00, 4'h5);
    rc(8'h0B, MODE_INSIDE, ADR_B, 8'h00, 4'h5);
    rc(8'h0B, MODE_INSIDE, 16'h2056, 8'h00, 4'h4);
    rc(8'h0B, MODE_OUTSIDE, 16'h0FFF, 8'h00, 4'h5);
    rc(8'h0B, MODE_OUTSIDE, ADR_A, 8'h00, 4'h4);
    rc(8'h0B, MODE_OUTSIDE, 16'h2056, 8'h00, 4'h5);
    rc(8'h0B, MODE_A_ONLY, ADR_A, 8'h00, 4'h6);
    rc(8'h0B, 4'h9, ADR_A, 8'h00, 4'h4);
    $display("test trigger modes finished");
    wr(OFS_TRIGGER, 32'h0000_0040);
    wr(OFS_CONTROL, 32'h0000_0003);
    rd(OFS_STATUS, 32'h0000_0007, 32'h0000_0004, "armed");
    cyc(ADR_A, 8'h00, 3'h4);
    rd(OFS_STATUS, 32'h0000_0007, 32'h0000_0005, "match A flag");
    wr(OFS_CONTROL, 32'h0000_0001);
    rd(OFS_STATUS, 32'h0000_0004, 32'h0000_0000, "stop by run bit");
    wr(OFS_CONTROL, 32'h0000_0003);
    rd(OFS_STATUS, 32'h0000_00F7, 32'h0000_0004, "rearmed");
    wr(OFS_CONTROL, 32'h0000_0002);
    rd(OFS_STATUS, 32'h0000_0004, 32'h0000_0000, "stop by enable");
    wr(OFS_TRIGGER, 32'h0000_0000);
    wr(OFS_CONTROL, 32'h0000_0003);
    ev(2, 16'h1234);
    ev(2, 16'h5678);
    ev(2, 16'h9ABC);
    cyc(ADR_A, 8'h00, 3'h4);
    rd(OFS_STATUS, 32'h0000_00F4, 32'h0000_0030, "end trace");
    rd(OFS_FIFO_HIGH, 32'h0000_00FF, 32'h0000_0012, "flow high");
    rd(OFS_FIFO_LOW, 32'h0000_00FF, 32'h0000_0034, "flow low");
    rd(OFS_FIFO_HIGH, 32'h0000_00FF, 32'h0000_0056, "next entry");
    wr(OFS_TRIGGER, 32'h0000_0040);
    wr(OFS_CONTROL, 32'h0000_0003);
    ev(2, 16'h1234);
    cyc(ADR_A, 8'h00, 3'h4);
    ev(2, 16'h5678);
    rd(OFS_STATUS, 32'h0000_00F4, 32'h0000_0014, "begin trace");
    wr(OFS_CONTROL, 32'h0000_0001);
    $display("test capture runs finished");
    // Begin bit left clear: event modes must still act as begin trace
    for (int m = 5; m <= 6; m++) begin
      wr(OFS_TRIGGER, 32'(m));
      wr(OFS_CONTROL, 32'h0000_0003);
      cyc(ADR_B, 8'hEE, 3'h4);
      cyc(ADR_A, 8'h00, 3'h4);
      for (int i = 0; i < 8; i++) cyc(ADR_B, 8'h10 + 8'(i), 3'h4);
      rd(OFS_STATUS, 32'h0000_00F4, 32'h0000_0080, "event full");
      for (int k = 0; k < FIFO_DEPTH; k++) begin
        e = (m == 5) ? ((k == 0) ? 8'hEE : 8'h0F + 8'(k)) : 8'h10 + 8'(k);
        rd(OFS_FIFO_LOW, 32'h0000_00FF, {24'h00_0000, e}, "event data");
      end
    end
    $display("test event runs finished");
    nt = i_cpu_core_model.n_tag;
    nb = i_cpu_core_model.n_halt;
    wr(OFS_TRIGGER, 32'h0000_0043);
    wr(OFS_CONTROL, 32'h0000_000F);
    cyc(ADR_A, 8'h00, 3'h5);
    ev(1, 16'h0000);
    cyc(16'h0200, 8'h00, 3'h5);
    ev(0, 16'h0000);
    @(posedge clk);
    chk("flushed tag", 32'(nb), 32'(i_cpu_core_model.n_halt));
    cyc(ADR_A, 8'h00, 3'h5);
    ev(0, 16'h0000);
    @(posedge clk);
    chk("tag marks", 32'(nt + 2), 32'(i_cpu_core_model.n_tag));
    chk("tag break", 32'(nb + 1), 32'(i_cpu_core_model.n_halt));
    wr(OFS_CONTROL, 32'h0000_0001);
    wr(OFS_TRIGGER, 32'h0000_00C0);
    wr(OFS_CONTROL, 32'h0000_000B);
    cyc(ADR_A, 8'h00, 3'h5);
    ev(1, 16'h0000);
    ev(0, 16'h0000);
    chk("flushed fetch", 32'h0000_0000, 32'(pend));
    cyc(ADR_A, 8'h00, 3'h5);
    chk("fetch only", 32'h0000_0000, 32'(pend));
    ev(0, 16'h0000);
    repeat (2) @(posedge clk);
    chk("executed fetch", 32'h0000_0001, 32'(pend));
    $display("test opcode tracking finished");
    end_of_test();
  end
endmodule : tb_debug_trigger_breakpoint
`default_nettype wire
